// >>> shared/pbi_pkg.sv
// shared constants, types and helper functions for the pci bus signal interface
package pbi_pkg;

  // ****************************************
  // bus commands
  // ****************************************
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // ****************************************
  // field positions, reset values, counts
  // ****************************************
  localparam int         CMD_WR_BIT   = 0;
  localparam logic [1:0] AD_LOW_ZERO  = 2'h0;
  localparam logic [31:0] MBOX_RST    = 32'h0;
  // subtractive claim after this many idle sample clocks (count from zero)
  localparam logic [2:0] SUB_WAIT     = 3'h2;
  // master abort when no target claims within this count (from zero)
  localparam logic [2:0] MABORT_WAIT  = 3'h4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_TSUB, ST_TDATA, ST_TEND, ST_IADDR, ST_IDATA, ST_IEND
  } pbi_st_type;

  typedef enum logic [1:0] {CR_RUN, CR_HIGH, CR_REL} pbi_cr_type;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        devsel_n;
  } pbi_bus_type;

  typedef struct packed {
    logic ad;
    logic cbe;
    logic frame;
    logic irdy;
    logic trdy;
    logic devsel;
  } pbi_oe_type;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be_n;
  } pbi_req_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic        abort;
  } pbi_rsp_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be_n;
    logic        cfg;
  } pbi_twr_type;

  localparam pbi_oe_type OE_ALL_OFF = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  // ****************************************
  // helpers
  // ****************************************
  // even parity over the 36 bus bits
  function automatic logic parity36(input logic [31:0] ad, input logic [3:0] cbe_n);
    parity36 = ^{ad, cbe_n};
  endfunction

  // byte lane i is taken only where its active-low enable i is low
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be_n);
    lane_merge = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (!be_n[i])
        lane_merge[8*i +: 8] = new_w[8*i +: 8];
    end
  endfunction

  function automatic logic win_hit(input logic [31:0] addr,
                                   input logic [31:0] base,
                                   input logic [31:0] mask);
    win_hit = ((addr ^ base) & mask) == 32'h0;
  endfunction

endpackage

// >>> design/pbi_sync.sv
// three-stage synchroniser that takes a change once the last two stages agree
`timescale 1ns/10ps
module pbi_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // data
  input  wire logic d_in,
  output logic      q_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff  <= 1'b0;
    end
    else
    begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        q_ff <= s3_ff;
    end
  end

  assign q_out = q_ff;

endmodule // pbi_sync

// >>> design/pbi_bridge.sv
// pci port signalling: target claim, single-phase initiator, clock run, parity
// What this block does
// - first clock carries 32-bit byte address, later clocks carry data
// - one address phase then at least one data phase per transaction
// - little-endian lanes: bits 7:0 lowest byte, 31:24 highest byte
// - as target: lines are inputs in address phase, then drive or capture data
// - as initiator: address on 31:2, zeros on 1:0, then write data or latch
// - data, command and select lines float in reset, after it and in suspend
// - command lines carry command in address phase, byte enables after
// - each active-low byte enable qualifies its own byte lane
// - command lines driven only as initiator, only watched as target
// - clock-run line warns of clock stop; peripherals pull it to keep clock
// - clock-run held low in and after reset, high during suspend
// - claim by positive decode, or by subtractive decode when enabled
// - claim own configuration cycles with select, internal hits, back-end hits
// - sample device select for initiator response and subtractive choice
// - device select floats from reset until driven as target
// - initiator frames the access; frame released marks the final phase
// - frame sampled as target, driven as initiator, else floating
// - a data phase completes when both ready lines are sampled low
// - reset pin states while reset is low, after-reset states at release
// - even parity over 36 bits, valid one bus clock after its phase
`timescale 1ns/10ps
module pbi_bridge
(
  // core clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // bus clock and bus reset
  input  wire logic                 pci_clk_in,
  input  wire logic                 bus_reset_n_in,
  // bus pins
  input  wire pbi_pkg::pbi_bus_type pci_in,
  output pbi_pkg::pbi_bus_type      pci_out,
  output pbi_pkg::pbi_oe_type       pci_oe_n_out,
  output logic                      par_out,
  output logic                      par_oe_n_out,
  input  wire logic                 idsel_in,
  input  wire logic                 gnt_n_in,
  input  wire logic                 clock_run_request_n_in,
  output logic                      clock_run_request_n_out,
  output logic                      clock_run_oe_n_out,
  // decode setup, bus domain, change only while bus reset is low
  input  wire logic [31:0]          int_base_in,
  input  wire logic [31:0]          int_mask_in,
  input  wire logic [31:0]          bkend_base_in,
  input  wire logic [31:0]          bkend_mask_in,
  input  wire logic                 sub_en_in,
  // core initiator requests
  input  wire logic                 ini_req_valid_in,
  input  wire pbi_pkg::pbi_req_type ini_req_in,
  output logic                      ini_req_ready_out,
  output logic                      ini_rsp_valid_out,
  output pbi_pkg::pbi_rsp_type      ini_rsp_out,
  // core target write reports
  output logic                      twr_valid_out,
  output pbi_pkg::pbi_twr_type      twr_out,
  // core power control
  input  wire logic                 pos_in,
  input  wire logic                 clk_stop_req_in,
  output logic                      clk_stop_ok_out
);

  // ****************************************
  // declarations
  // ****************************************
  pbi_pkg::pbi_st_type  st_ff,  nxt_st;
  pbi_pkg::pbi_cr_type  cr_ff,  nxt_cr;
  pbi_pkg::pbi_bus_type out_ff, nxt_out;
  pbi_pkg::pbi_oe_type  oe_ff,  nxt_oe;
  pbi_pkg::pbi_rsp_type rsp_ff, nxt_rsp;
  pbi_pkg::pbi_twr_type twr_ff, nxt_twr;
  pbi_pkg::pbi_req_type req_hold_ff;
  pbi_pkg::pbi_rsp_type rsp_out_ff;
  pbi_pkg::pbi_twr_type twr_out_ff;
  logic [2:0]  cnt_ff,  nxt_cnt;
  logic [3:0]  cmd_ff,  nxt_cmd;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] mbox_ff, nxt_mbox;
  logic        done_tgl_ff, nxt_done_tgl;
  logic        twr_tgl_ff,  nxt_twr_tgl;
  logic        req_seen_ff, nxt_req_seen;
  logic        cr_out_ff, nxt_cr_out;
  logic        cr_oe_n_ff, nxt_cr_oe_n;
  logic        frame_prev_ff;
  logic        par_ff;
  logic        par_oe_n_ff;
  logic        claim;
  logic        req_tgl_ff;
  logic        busy_ff;
  logic        done_seen_ff;
  logic        twr_seen_ff;
  logic        rsp_valid_ff;
  logic        twr_valid_ff;
  logic        req_q, pos_s, stop_s, done_q, twr_q;

  // ****************************************
  // crossings
  // ****************************************
  pbi_sync u_req  (.clk_in(pci_clk_in), .rstn_in(bus_reset_n_in), .d_in(req_tgl_ff),
                   .q_out(req_q));
  pbi_sync u_pos  (.clk_in(pci_clk_in), .rstn_in(bus_reset_n_in), .d_in(pos_in),
                   .q_out(pos_s));
  pbi_sync u_stop (.clk_in(pci_clk_in), .rstn_in(bus_reset_n_in), .d_in(clk_stop_req_in),
                   .q_out(stop_s));
  pbi_sync u_done (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(done_tgl_ff), .q_out(done_q));
  pbi_sync u_twr  (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(twr_tgl_ff), .q_out(twr_q));
  pbi_sync u_ok   (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(cr_ff == pbi_pkg::CR_REL),
                   .q_out(clk_stop_ok_out));

  // ****************************************
  // bus decode
  // ****************************************
  // a falling frame opens a new access
  wire addr_phase = !pci_in.frame_n && frame_prev_ff;
  wire bus_idle   = pci_in.frame_n && pci_in.irdy_n;
  // both ready lines low completes a data phase
  wire xfer       = !pci_in.irdy_n && !pci_in.trdy_n;
  wire req_pend   = req_q != req_seen_ff;
  wire is_cfg     = pci_in.cbe_n == pbi_pkg::CMD_CFG_RD || pci_in.cbe_n == pbi_pkg::CMD_CFG_WR;
  wire is_io_mem  = pci_in.cbe_n == pbi_pkg::CMD_IO_RD  || pci_in.cbe_n == pbi_pkg::CMD_IO_WR ||
                    pci_in.cbe_n == pbi_pkg::CMD_MEM_RD || pci_in.cbe_n == pbi_pkg::CMD_MEM_WR;
  // own config with select, internal window, or back-end window
  wire pos_hit    = (is_cfg && idsel_in) ||
                    (is_io_mem && pbi_pkg::win_hit(pci_in.ad, int_base_in, int_mask_in)) ||
                    (is_io_mem && pbi_pkg::win_hit(pci_in.ad, bkend_base_in, bkend_mask_in));

  // ****************************************
  // bus state machine
  // ****************************************
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_out      = out_ff;
    nxt_oe       = oe_ff;
    nxt_cnt      = cnt_ff;
    nxt_cmd      = cmd_ff;
    nxt_addr     = addr_ff;
    nxt_mbox     = mbox_ff;
    nxt_rsp      = rsp_ff;
    nxt_twr      = twr_ff;
    nxt_done_tgl = done_tgl_ff;
    nxt_twr_tgl  = twr_tgl_ff;
    nxt_req_seen = req_seen_ff;
    claim        = 1'b0;
    unique case (st_ff)
      pbi_pkg::ST_IDLE:
      begin
        if (pos_s)
          nxt_st = pbi_pkg::ST_IDLE;
        // target takes the address phase as input
        else if (addr_phase)
        begin
          nxt_cmd  = pci_in.cbe_n;
          nxt_addr = pci_in.ad;
          // positive claim first, subtractive only if enabled
          if (pos_hit)
            claim = 1'b1;
          else if (sub_en_in && is_io_mem)
          begin
            nxt_st  = pbi_pkg::ST_TSUB;
            nxt_cnt = 3'h0;
          end
        end
        // aligned address with zero low bits, command on cbe
        else if (req_pend && !gnt_n_in && bus_idle)
        begin
          nxt_st        = pbi_pkg::ST_IADDR;
          nxt_req_seen  = req_q;
          nxt_cmd       = req_hold_ff.cmd;
          nxt_out.ad    = {req_hold_ff.addr[31:2], pbi_pkg::AD_LOW_ZERO};
          nxt_out.cbe_n = req_hold_ff.cmd;
          nxt_out.frame_n = 1'b0;
          nxt_out.irdy_n  = 1'b1;
          nxt_oe.ad    = 1'b0;
          nxt_oe.cbe   = 1'b0;
          nxt_oe.frame = 1'b0;
          nxt_oe.irdy  = 1'b0;
        end
      end
      pbi_pkg::ST_TSUB:
      begin
        // another target answered, or the access ended unclaimed
        if (!pci_in.devsel_n || bus_idle)
          nxt_st = pbi_pkg::ST_IDLE;
        else if (cnt_ff == pbi_pkg::SUB_WAIT)
          claim = 1'b1;
        else
          nxt_cnt = cnt_ff + 3'h1;
      end
      pbi_pkg::ST_TDATA:
      begin
        if (xfer)
        begin
          if (cmd_ff[pbi_pkg::CMD_WR_BIT])
          begin
            // only enabled lanes update the mailbox
            nxt_mbox    = pbi_pkg::lane_merge(mbox_ff, pci_in.ad, pci_in.cbe_n);
            nxt_twr     = '{addr_ff, pci_in.ad, pci_in.cbe_n,
                            cmd_ff == pbi_pkg::CMD_CFG_WR};
            nxt_twr_tgl = ~twr_tgl_ff;
          end
          if (pci_in.frame_n)
          begin
            nxt_st          = pbi_pkg::ST_TEND;
            nxt_out.devsel_n = 1'b1;
            nxt_out.trdy_n  = 1'b1;
            nxt_oe.ad       = 1'b1;
          end
        end
      end
      pbi_pkg::ST_TEND:
      begin
        // sustained lines driven high one clock before release
        nxt_st        = pbi_pkg::ST_IDLE;
        nxt_oe.devsel = 1'b1;
        nxt_oe.trdy   = 1'b1;
      end
      pbi_pkg::ST_IADDR:
      begin
        nxt_st          = pbi_pkg::ST_IDATA;
        nxt_cnt         = 3'h0;
        nxt_out.frame_n = 1'b1;
        nxt_out.irdy_n  = 1'b0;
        nxt_out.cbe_n   = req_hold_ff.be_n;
        nxt_out.ad      = req_hold_ff.wdata;
        nxt_oe.ad       = !cmd_ff[pbi_pkg::CMD_WR_BIT];
      end
      pbi_pkg::ST_IDATA:
      begin
        if (xfer || (pci_in.devsel_n && cnt_ff == pbi_pkg::MABORT_WAIT))
        begin
          nxt_st         = pbi_pkg::ST_IEND;
          nxt_rsp        = '{pci_in.ad, !xfer};
          nxt_done_tgl   = ~done_tgl_ff;
          nxt_out.irdy_n = 1'b1;
          nxt_oe.ad      = 1'b1;
          nxt_oe.cbe     = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 3'h1;
      end
      pbi_pkg::ST_IEND:
      begin
        nxt_st       = pbi_pkg::ST_IDLE;
        nxt_oe.frame = 1'b1;
        nxt_oe.irdy  = 1'b1;
      end
    endcase
    // claim drives select and ready; reads return the mailbox
    if (claim)
    begin
      nxt_st           = pbi_pkg::ST_TDATA;
      nxt_out.devsel_n = 1'b0;
      nxt_out.trdy_n   = 1'b0;
      nxt_out.ad       = mbox_ff;
      nxt_oe.devsel    = 1'b0;
      nxt_oe.trdy      = 1'b0;
      nxt_oe.ad        = nxt_cmd[pbi_pkg::CMD_WR_BIT];
    end
  end

  // ****************************************
  // clock run
  // ****************************************
  // a stop is only offered while the bus is quiet; any pull-down cancels it
  always_comb
  begin
    nxt_cr      = cr_ff;
    nxt_cr_out  = 1'b0;
    nxt_cr_oe_n = 1'b0;
    unique case (cr_ff)
      pbi_pkg::CR_RUN:
      begin
        // high during suspend or when a stop is offered, otherwise held low
        if (pos_s)
          nxt_cr_out = 1'b1;
        else if (stop_s && st_ff == pbi_pkg::ST_IDLE && bus_idle)
        begin
          nxt_cr     = pbi_pkg::CR_HIGH;
          nxt_cr_out = 1'b1;
        end
      end
      pbi_pkg::CR_HIGH:
      begin
        nxt_cr      = pbi_pkg::CR_REL;
        nxt_cr_oe_n = 1'b1;
      end
      pbi_pkg::CR_REL:
      begin
        // peripheral request or core change of mind restarts
        if (!stop_s || !clock_run_request_n_in || pos_s)
          nxt_cr = pbi_pkg::CR_RUN;
        else
          nxt_cr_oe_n = 1'b1;
      end
      default:
        nxt_cr = pbi_pkg::CR_RUN;
    endcase
  end

  // ****************************************
  // bus domain registers
  // ****************************************
  // every bus pin flop runs on the rising bus clock
  // reset values give the pin states during and after reset
  always_ff @(posedge pci_clk_in or negedge bus_reset_n_in)
  begin
    if (!bus_reset_n_in)
    begin
      st_ff         <= pbi_pkg::ST_IDLE;
      cr_ff         <= pbi_pkg::CR_RUN;
      out_ff        <= '1;
      oe_ff         <= pbi_pkg::OE_ALL_OFF;
      cnt_ff        <= 3'h0;
      cmd_ff        <= 4'h0;
      addr_ff       <= 32'h0;
      mbox_ff       <= pbi_pkg::MBOX_RST;
      rsp_ff        <= '0;
      twr_ff        <= '0;
      done_tgl_ff   <= 1'b0;
      twr_tgl_ff    <= 1'b0;
      req_seen_ff   <= 1'b0;
      cr_out_ff     <= 1'b0;
      cr_oe_n_ff    <= 1'b0;
      frame_prev_ff <= 1'b1;
      par_ff        <= 1'b0;
      par_oe_n_ff   <= 1'b1;
    end
    else
    begin
      st_ff         <= nxt_st;
      cr_ff         <= nxt_cr;
      out_ff        <= nxt_out;
      oe_ff         <= nxt_oe;
      cnt_ff        <= nxt_cnt;
      cmd_ff        <= nxt_cmd;
      addr_ff       <= nxt_addr;
      mbox_ff       <= nxt_mbox;
      rsp_ff        <= nxt_rsp;
      twr_ff        <= nxt_twr;
      done_tgl_ff   <= nxt_done_tgl;
      twr_tgl_ff    <= nxt_twr_tgl;
      req_seen_ff   <= nxt_req_seen;
      cr_out_ff     <= nxt_cr_out;
      cr_oe_n_ff    <= nxt_cr_oe_n;
      frame_prev_ff <= pci_in.frame_n;
      // parity follows the phase it covers by one clock
      par_ff        <= pbi_pkg::parity36(pci_in.ad, pci_in.cbe_n);
      par_oe_n_ff   <= pci_oe_n_out.ad;
    end
  end

  // suspend floats data, command and select at once
  // command lines only leave the floating state as initiator
  assign pci_out                 = out_ff;
  assign pci_oe_n_out            = oe_ff | {6{pos_s}};
  assign par_out                 = par_ff;
  assign par_oe_n_out            = par_oe_n_ff | pos_s;
  assign clock_run_request_n_out = cr_out_ff;
  assign clock_run_oe_n_out      = cr_oe_n_ff;

  // ****************************************
  // core side
  // ****************************************
  // request words stay frozen while busy, so the bus side reads them safely
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      req_hold_ff  <= '0;
      req_tgl_ff   <= 1'b0;
      busy_ff      <= 1'b0;
      done_seen_ff <= 1'b0;
      twr_seen_ff  <= 1'b0;
      rsp_out_ff   <= '0;
      twr_out_ff   <= '0;
      rsp_valid_ff <= 1'b0;
      twr_valid_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= done_q != done_seen_ff;
      twr_valid_ff <= twr_q != twr_seen_ff;
      done_seen_ff <= done_q;
      twr_seen_ff  <= twr_q;
      if (ini_req_valid_in && !busy_ff)
      begin
        req_hold_ff <= ini_req_in;
        req_tgl_ff  <= ~req_tgl_ff;
        busy_ff     <= 1'b1;
      end
      else if (done_q != done_seen_ff)
        busy_ff <= 1'b0;
      if (done_q != done_seen_ff)
        rsp_out_ff <= rsp_ff;
      // back-to-back target writes faster than the crossing keep only the last
      if (twr_q != twr_seen_ff)
        twr_out_ff <= twr_ff;
    end
  end

  assign ini_req_ready_out = !busy_ff;
  assign ini_rsp_valid_out = rsp_valid_ff;
  assign ini_rsp_out       = rsp_out_ff;
  assign twr_valid_out     = twr_valid_ff;
  assign twr_out           = twr_out_ff;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_ini_addr;
    st_ff == pbi_pkg::ST_IADDR && !pci_out.frame_n && !pci_oe_n_out.cbe;
  endsequence
  sequence s_ini_last;
    pci_out.frame_n && !pci_out.irdy_n && pci_out.cbe_n == req_hold_ff.be_n;
  endsequence

  addr_low_zero_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    st_ff == pbi_pkg::ST_IADDR |-> pci_out.ad[1:0] == 2'h0 && !pci_oe_n_out.ad)
    else $error("initiator address low bits not zero");
  frame_single_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    s_ini_addr |=> s_ini_last)
    else $error("address phase not followed by final data phase");
  cbe_owner_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    !pci_oe_n_out.cbe |-> st_ff == pbi_pkg::ST_IADDR || st_ff == pbi_pkg::ST_IDATA)
    else $error("command lines driven outside initiator phases");
  reset_float_a: assert property (
    @(posedge pci_clk_in)
    $rose(bus_reset_n_in) |-> pci_oe_n_out == pbi_pkg::OE_ALL_OFF && !clock_run_oe_n_out &&
                              !clock_run_request_n_out)
    else $error("pins not in after-reset state");
  pos_float_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    pos_s |-> pci_oe_n_out.ad && pci_oe_n_out.cbe && pci_oe_n_out.devsel)
    else $error("bus lines driven during suspend");
  clock_run_request_n_pos_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    pos_s && cr_ff == pbi_pkg::CR_RUN |=> clock_run_request_n_out && !clock_run_oe_n_out)
    else $error("clock run not high during suspend");
  par_delay_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    !pci_oe_n_out.ad |=> par_out == pbi_pkg::parity36($past(pci_in.ad), $past(pci_in.cbe_n)))
    else $error("parity wrong one clock after phase");
  cfg_claim_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    st_ff == pbi_pkg::ST_IDLE && !pos_s && addr_phase && is_cfg && idsel_in
      |=> !pci_out.devsel_n && !pci_oe_n_out.devsel ##1 st_ff != pbi_pkg::ST_IDLE)
    else $error("own configuration cycle not claimed");
  mbox_lane_a: assert property (
    @(posedge pci_clk_in) disable iff (!bus_reset_n_in)
    st_ff == pbi_pkg::ST_TDATA && xfer && cmd_ff[pbi_pkg::CMD_WR_BIT]
      |=> mbox_ff == pbi_pkg::lane_merge($past(mbox_ff), $past(pci_in.ad), $past(pci_in.cbe_n)))
    else $error("target write not merged by byte enables");

endmodule // pbi_bridge

// >>> testbench/pbi_far_agent.sv
// far-side bus agent: claims bridge cycles as target, starts cycles as initiator
`timescale 1ns/10ps
module pbi_far_agent
(
  // bridge pins
  input  wire logic                 clk_in,
  input  wire pbi_pkg::pbi_bus_type d_in,
  input  wire pbi_pkg::pbi_oe_type  oe_in,
  // wire levels
  output pbi_pkg::pbi_bus_type      bus_out
);
  pbi_pkg::pbi_bus_type m = '0;
  pbi_pkg::pbi_oe_type  e = '0;
  logic                 claim = 1'h0;
  logic [31:0]          rdv = 32'h5a6b_7c8d;
  logic [31:0]          aph;
  logic [31:0]          wd;
  logic [3:0]           acmd;
  // ********
  // wire levels, bridge first, released lines read high
  // ********
  wire [39:0] dm = {{32{!oe_in.ad}}, {4{!oe_in.cbe}}, ~oe_in[3:0]};
  wire [39:0] pm = {{32{e.ad}}, {4{e.cbe}}, e[3:0]};
  assign bus_out = (dm & d_in) | (~dm & pm & m) | ~(dm | pm);
  always @(posedge clk_in)
  begin
    if (!oe_in.frame && !d_in.frame_n)
    begin
      aph <= bus_out.ad;
      acmd <= bus_out.cbe_n;
      e <= {claim & !bus_out.cbe_n[0], 3'h0, claim, claim};
      m.ad <= rdv;
    end
    else if (e.trdy && !bus_out.irdy_n)
    begin
      wd <= bus_out.ad;
      e <= '0;
    end
  end
  // one address phase, one data phase
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] dv,
                      input logic [3:0] be, output logic [31:0] r);
    r = 'x;
    @(posedge clk_in);
    m <= {a, c, 4'h4};
    e <= 6'h3c;
    @(posedge clk_in);
    m <= {dv, be, 4'h8};
    e <= {c[0], 5'h1c};
    @(posedge clk_in);
    repeat (8) if (bus_out.trdy_n !== 1'h0) @(posedge clk_in);
    r = bus_out.ad;
    e <= '0;
  endtask
endmodule // pbi_far_agent

// >>> testbench/pci_bus_signal_interface_bench.sv
// self-checking bench for the bus bridge
`timescale 1ns/10ps
module pci_bus_signal_interface_bench;
  logic                 clk_in = 1'h0;
  logic                 pclk = 1'h0;
  logic                 rstn_in = 1'h0;
  logic                 brst_n = 1'h0;
  logic                 pos = 1'h0;
  logic                 stop = 1'h0;
  logic                 rqv = 1'h0;
  logic                 idsel = 1'h0;
  logic                 sub = 1'h0;
  pbi_pkg::pbi_req_type rq = '0;
  pbi_pkg::pbi_bus_type bus;
  pbi_pkg::pbi_bus_type dout;
  pbi_pkg::pbi_oe_type  oe;
  pbi_pkg::pbi_rsp_type rsp;
  pbi_pkg::pbi_twr_type tw;
  logic                 rdy, rsv, twv, ok, cro, croe;
  logic [31:0]          r;
  int                   bad_count = 0;
  int                   samples_checked = 0;
  always #25 clk_in = ~clk_in;
  always #32 pclk = ~pclk;
  pbi_bridge dut_u
  (
    .clk_in(clk_in), .rstn_in(rstn_in), .pci_clk_in(pclk), .bus_reset_n_in(brst_n),
    .pci_in(bus), .pci_out(dout), .pci_oe_n_out(oe), .par_out(), .par_oe_n_out(),
    .idsel_in(idsel), .gnt_n_in(1'h0), .clock_run_request_n_in(croe | cro),
    .clock_run_request_n_out(cro), .clock_run_oe_n_out(croe),
    .int_base_in(32'h0000_1000), .int_mask_in(32'hffff_ff00),
    .bkend_base_in(32'h0003_0000), .bkend_mask_in(32'hffff_0000), .sub_en_in(sub),
    .ini_req_valid_in(rqv), .ini_req_in(rq), .ini_req_ready_out(rdy),
    .ini_rsp_valid_out(rsv), .ini_rsp_out(rsp), .twr_valid_out(twv), .twr_out(tw),
    .pos_in(pos), .clk_stop_req_in(stop), .clk_stop_ok_out(ok)
  );
  pbi_far_agent p_u (.clk_in(pclk), .d_in(dout), .oe_in(oe), .bus_out(bus));
  // ********
  // checks and scenarios
  // ********
  task chk(input logic [31:0] g, input logic [31:0] x, input string s);
    samples_checked++;
    if (g !== x)
    begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask
  task t_float(input logic [1:0] cr);
    chk(32'(oe), 32'(pbi_pkg::OE_ALL_OFF), "bus lines not floating");
    chk(32'({croe, cro}), 32'(cr), "clock run level");
  endtask
  task t_twr(input logic [3:0] c, input logic [31:0] d, input logic [3:0] be);
    p_u.xfer(c, 32'h0000_1004, d, be, r);
    repeat (40) if (twv !== 1'h1) @(negedge clk_in);
    chk({tw.addr[7:0], tw.be_n, 19'h0, tw.cfg}, {8'h04, be, 19'h0, c[3]}, "write report");
  endtask
  task t_ini(input logic [3:0] c, input logic cl);
    p_u.claim = cl;
    @(negedge clk_in);
    rq = {c, 32'h0000_2007, 32'hcafe_f00d, 4'h0};
    rqv = 1'h1;
    @(negedge clk_in);
    rqv = 1'h0;
    chk(32'(rdy), 32'h0, "ready while busy");
    repeat (400) if (rsv !== 1'h1) @(negedge clk_in);
    chk(32'(rdy), 32'h1, "ready after response");
    chk(32'(rsp.abort), 32'(!cl), "abort flag");
    chk(p_u.aph, 32'h0000_2004, "address phase");
    chk(32'(p_u.acmd), 32'(c), "command");
    if (cl)
      chk(c[0] ? p_u.wd : rsp.rdata, c[0] ? 32'hcafe_f00d : p_u.rdv, "data");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk_in);
    t_float(2'h0);
    repeat (10) @(negedge clk_in);
    rstn_in = 1'h1;
    brst_n = 1'h1;
    @(negedge clk_in);
    t_float(2'h0);
    t_twr(pbi_pkg::CMD_MEM_WR, 32'h1122_3344, 4'ha);
    p_u.xfer(pbi_pkg::CMD_MEM_RD, 32'h0000_1004, 32'h0, 4'h0, r);
    chk(r, 32'h0022_0044, "lane merge");
    p_u.xfer(pbi_pkg::CMD_MEM_RD, 32'h0000_8000, 32'h0, 4'h0, r);
    chk(r, 32'hffff_ffff, "miss claimed without subtractive");
    @(negedge clk_in);
    sub = 1'h1;
    p_u.xfer(pbi_pkg::CMD_MEM_RD, 32'h0000_8000, 32'h0, 4'h0, r);
    chk(r, 32'h0022_0044, "subtractive claim");
    p_u.xfer(pbi_pkg::CMD_CFG_RD, 32'h0, 32'h0, 4'h0, r);
    chk(r, 32'hffff_ffff, "config without select claimed");
    @(negedge clk_in);
    idsel = 1'h1;
    t_twr(pbi_pkg::CMD_CFG_WR, 32'h0, 4'h0);
    t_ini(pbi_pkg::CMD_MEM_WR, 1'h1);
    t_ini(pbi_pkg::CMD_IO_RD, 1'h1);
    t_ini(pbi_pkg::CMD_MEM_RD, 1'h0);
    stop = 1'h1;
    repeat (40) if (ok !== 1'h1) @(negedge clk_in);
    chk(32'(ok), 32'h1, "clock stop");
    pos = 1'h1;
    repeat (12) @(negedge clk_in);
    t_float(2'h1);
    complete_run;
  end
  initial
  begin
    #2000000;
    bad_count++;
    complete_run;
  end
endmodule // pci_bus_signal_interface_bench
